/* include/p5g_params.svh */
// p5g_params.svh: register offsets, field positions and reset values of the port block
// assumes: included by the port package, p5g_port and p5g_sync, never by itself compiled
`ifndef P5G_PARAMS_SVH
`define P5G_PARAMS_SVH

// port geometry
`define P5G_PINS 8
`define P5G_WAKE_PINS 6
`define P5G_ADDR_W 3
`define P5G_DATA_W 8

// register offsets on the plain register port
`define P5G_OFS_MODE 3'h0
`define P5G_OFS_DIR 3'h1
`define P5G_OFS_DATA 3'h2
`define P5G_OFS_PULL 3'h3
`define P5G_OFS_FUNC 3'h4

// reset values
`define P5G_RST_MODE 8'h00
`define P5G_RST_DIR 8'h00
`define P5G_RST_DATA 8'h00
`define P5G_RST_PULL 8'h00

// field positions
`define P5G_BIT_SCL 7
`define P5G_BIT_SDA 6
`define P5G_BIT_TRIG 5
`define P5G_PULL_MASK 8'h3f

// input synchroniser depth
`define P5G_SYNC_STAGES 3

`endif

/* include/p5g_pkg.sv */
// p5g_pkg: types shared by the port block modules
// assumes: p5g_params.svh is reachable on the include path
`include "p5g_params.svh"

package p5g_pkg;

  // one register access from software
  typedef struct packed {
    logic [`P5G_ADDR_W-1:0] addr;
    logic [`P5G_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } p5g_bus_req_t;

  // what the port logic decides for one pin
  typedef struct packed {
    logic tw_sel;
    logic tw_low;
    logic gpio_out;
    logic open_drain;
    logic data;
    logic pull_req;
  } p5g_pin_cfg_t;

  // what one pin cell drives onto the pad
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pu;
  } p5g_pin_drive_t;

  // whole register state of the port
  typedef struct packed {
    logic [`P5G_DATA_W-1:0] mode;
    logic [`P5G_DATA_W-1:0] dir;
    logic [`P5G_DATA_W-1:0] data;
    logic [`P5G_WAKE_PINS-1:0] pull;
    logic [`P5G_DATA_W-1:0] rdata;
  } p5g_port_state_t;

endpackage : p5g_pkg

/* src/p5g_pin_cell.sv */
// p5g_pin_cell: drive decision for one port pin
// assumes: configuration is already resolved by the port's priority logic
`timescale 1ns/100ps

module p5g_pin_cell
  import p5g_pkg::*;
(
  input wire p5g_pin_cfg_t i_cfg,
  output p5g_pin_drive_t o_drive
);

  always_comb begin
    o_drive = '{out: 1'b0, oe_n: 1'b1, pu: 1'b0};
    if (i_cfg.tw_sel) begin
      // two-wire line: open drain, only ever pulls low
      o_drive.oe_n = ~i_cfg.tw_low;
    end else if (i_cfg.gpio_out) begin
      if (i_cfg.open_drain) begin
        // pmos cut off: a one is released, not driven
        o_drive.oe_n = i_cfg.data;
      end else begin
        o_drive.out = i_cfg.data;
        o_drive.oe_n = 1'b0;
      end
    end else begin
      o_drive.pu = i_cfg.pull_req;
    end
  end

endmodule // p5g_pin_cell

/* src/p5g_port.sv */
// p5g_port: eight-pin general purpose port with mode, direction, data and pull-up registers
// assumes: a single 10 MHz clock, a plain register port from the cpu, an external pad ring
// that resolves out/oe_n into a wire, and the two-wire controller on the same clock.
//
// Operation
// - direction bit one output, zero input
// - direction ignored on pins claimed elsewhere; code still uses it for their pull-up and read-back
// - data register holds general output value
// - output bits read back latch value
// - input bits read back live pin
// - pull-up bit one on, zero off
// - pull-up only acts on input pins
// - pull-up bits seven, six read zero
// - two-wire enable claims pins seven, six
// - clock line is open drain only
// - data line is open drain only
// - mode bit makes pin wakeup input
// - mode settings beat general port settings
// - open-drain select for pins seven, six
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "p5g_params.svh"

module p5g_port
  import p5g_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register port
  input wire logic [`P5G_ADDR_W-1:0] i_addr,
  input wire logic [`P5G_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`P5G_DATA_W-1:0] o_rdata,
  // pads
  input wire logic [`P5G_PINS-1:0] i_pin_in,
  output logic [`P5G_PINS-1:0] o_pin_out,
  output logic [`P5G_PINS-1:0] o_pin_oe_n,
  output logic [`P5G_PINS-1:0] o_pin_pullup,
  // two-wire controller side
  input wire logic i_twowire_enable,
  input wire logic i_scl_drive_low,
  input wire logic i_sda_drive_low,
  output logic o_scl_in,
  output logic o_sda_in,
  // wakeup and conversion trigger side
  output logic [`P5G_WAKE_PINS-1:0] o_wakeup_in,
  output logic [`P5G_WAKE_PINS-1:0] o_wakeup_sel,
  output logic o_conversion_trigger_in,
  output logic o_conversion_trigger_sel
);

  p5g_bus_req_t bus;
  p5g_port_state_t state_reg;
  p5g_port_state_t state_next;

  // synchronised pad levels
  logic [`P5G_PINS-1:0] pin_level;

  // per-pin resolved function
  logic [`P5G_PINS-1:0] claimed;
  logic [`P5G_PINS-1:0] gpio_out;
  logic [`P5G_PINS-1:0] wake_mode;
  logic [`P5G_PINS-1:0] tw_mode;
  logic [`P5G_PINS-1:0] tw_low;
  logic [`P5G_PINS-1:0] open_drain;
  logic [`P5G_PINS-1:0] pull_req;
  logic [`P5G_PINS-1:0] data_view;
  logic [`P5G_PINS-1:0] func_view;

  p5g_pin_cfg_t [`P5G_PINS-1:0] pin_cfg;
  p5g_pin_drive_t [`P5G_PINS-1:0] pin_drive;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  p5g_sync #(
    .WIDTH(`P5G_PINS)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_pin_in),
    .o_level(pin_level)
  );

  // pin function resolution
  always_comb begin
    wake_mode = '0;
    tw_mode = '0;
    tw_low = '0;
    open_drain = '0;
    wake_mode[`P5G_WAKE_PINS-1:0] = state_reg.mode[`P5G_WAKE_PINS-1:0];
    tw_mode[`P5G_BIT_SCL] = i_twowire_enable;
    tw_mode[`P5G_BIT_SDA] = i_twowire_enable;
    tw_low[`P5G_BIT_SCL] = i_scl_drive_low;
    tw_low[`P5G_BIT_SDA] = i_sda_drive_low;
    open_drain[`P5G_BIT_SCL] = state_reg.mode[`P5G_BIT_SCL];
    open_drain[`P5G_BIT_SDA] = state_reg.mode[`P5G_BIT_SDA];
  end

  assign claimed = wake_mode | tw_mode;

  assign gpio_out = state_reg.dir & ~claimed;

  // pull-up: the resistor is only meaningful on a pin that nobody drives, so a claimed
  // wakeup pin still takes it while its direction bit is clear
  always_comb begin
    pull_req = '0;
    pull_req[`P5G_WAKE_PINS-1:0] = state_reg.pull & ~state_reg.dir[`P5G_WAKE_PINS-1:0];
  end

  // one pin cell per pad
  genvar gi;
  generate
    for (gi = 0; gi < `P5G_PINS; gi++) begin : g_pin
      always_comb begin
        pin_cfg[gi].tw_sel = tw_mode[gi];
        pin_cfg[gi].tw_low = tw_low[gi];
        pin_cfg[gi].gpio_out = gpio_out[gi];
        pin_cfg[gi].open_drain = open_drain[gi];
        pin_cfg[gi].data = state_reg.data[gi];
        pin_cfg[gi].pull_req = pull_req[gi];
      end

      p5g_pin_cell u_cell (
        .i_cfg(pin_cfg[gi]),
        .o_drive(pin_drive[gi])
      );

      assign o_pin_out[gi] = pin_drive[gi].out;
      assign o_pin_oe_n[gi] = pin_drive[gi].oe_n;
      assign o_pin_pullup[gi] = pin_drive[gi].pu;
      // a pin counts as driven whenever the pad enable is active
      assign func_view[gi] = ~pin_drive[gi].oe_n;
    end
  endgenerate

  // data register read view
  // output bits show latch
  assign data_view = (state_reg.data & state_reg.dir) | (pin_level & ~state_reg.dir);

  // register file
  always_comb begin
    state_next = state_reg;
    // read data stand for exactly one cycle after the strobe
    state_next.rdata = '0;

    if (bus.wr) begin
      case (bus.addr)
        `P5G_OFS_MODE: begin
          state_next.mode = bus.wdata;
        end
        `P5G_OFS_DIR: begin
          state_next.dir = bus.wdata;
        end
        `P5G_OFS_DATA: begin
          state_next.data = bus.wdata;
        end
        `P5G_OFS_PULL: begin
          state_next.pull = bus.wdata[`P5G_WAKE_PINS-1:0];
        end
        default: begin
          // unmapped and read-only offsets ignore writes
          state_next.mode = state_reg.mode;
        end
      endcase
    end

    if (bus.rd) begin
      case (bus.addr)
        `P5G_OFS_MODE: begin
          state_next.rdata = state_reg.mode;
        end
        `P5G_OFS_DIR: begin
          // write-only register: software keeps its own copy
          state_next.rdata = '0;
        end
        `P5G_OFS_DATA: begin
          state_next.rdata = data_view;
        end
        `P5G_OFS_PULL: begin
          state_next.rdata = {2'h0, state_reg.pull} & `P5G_PULL_MASK;
        end
        `P5G_OFS_FUNC: begin
          state_next.rdata = func_view;
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_reg.mode <= `P5G_RST_MODE;
      state_reg.dir <= `P5G_RST_DIR;
      state_reg.data <= `P5G_RST_DATA;
      state_reg.pull <= '0;
      state_reg.rdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;

  assign o_scl_in = pin_level[`P5G_BIT_SCL];
  assign o_sda_in = pin_level[`P5G_BIT_SDA];
  assign o_wakeup_in = pin_level[`P5G_WAKE_PINS-1:0];
  assign o_conversion_trigger_in = pin_level[`P5G_BIT_TRIG];

  assign o_wakeup_sel = state_reg.mode[`P5G_WAKE_PINS-1:0];
  assign o_conversion_trigger_sel = state_reg.mode[`P5G_BIT_TRIG];

endmodule // p5g_port

/* src/p5g_sync.sv */
// p5g_sync: three-stage input synchroniser with agreement filter
// assumes: inputs are asynchronous pad levels; output is settled on i_clock
`timescale 1ns/100ps
`include "p5g_params.svh"

module p5g_sync
  import p5g_pkg::*;
#(
  parameter int WIDTH = `P5G_PINS
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } p5g_sync_state_t;

  p5g_sync_state_t state_reg;
  p5g_sync_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.s1 = i_async;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // s1 is only read by s2; a bit changes once s2 and s3 agree
    for (int i = 0; i < WIDTH; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.level[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level = state_reg.level;

endmodule // p5g_sync

/* verification/p5g_pad_model.sv */
// p5g_pad_model: external circuitry on the eight pads
// assumes: pins 7,6 carry bus pull-ups; a floating pin without pull-up wanders
`timescale 1ns/100ps

module p5g_pad_model (
  input wire logic i_clock,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_level
);
  logic [7:0] last_reg;
  always_ff @(posedge i_clock) last_reg <= o_level;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!i_oe_n[i]) o_level[i] = i_out[i];
      else if (i_ext_en[i]) o_level[i] = i_ext_val[i];
      else if (i_pullup[i] || i >= 6) o_level[i] = 1'b1;
      else o_level[i] = ~last_reg[i];
    end
  end
endmodule // p5g_pad_model

/* verification/p5g_port_bench.sv */
// p5g_port_bench: directed tests through the register port and pads
// assumes: pad model resolves pins, checker bound by its own file
`timescale 1ns/100ps

module p5g_port_bench;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic tw_en = 1'b0;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'h3f;
  wire [7:0] rdata, pin, pout, poe_n, pup;
  wire scl_in, sda_in, trig_in, trig_sel;
  wire [5:0] wk_in, wk_sel;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  p5g_port dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe_n(poe_n), .o_pin_pullup(pup),
    .i_twowire_enable(tw_en), .i_scl_drive_low(scl_low), .i_sda_drive_low(sda_low), .o_scl_in(scl_in),
    .o_sda_in(sda_in), .o_wakeup_in(wk_in), .o_wakeup_sel(wk_sel), .o_conversion_trigger_in(trig_in),
    .o_conversion_trigger_sel(trig_sel));
  p5g_pad_model pads (.i_clock(i_clock), .i_out(pout), .i_oe_n(poe_n), .i_pullup(pup), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_level(pin));

  initial forever #50 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk("rdata", rdata, exp);
  endtask
  // synchroniser needs up to four edges
  task automatic settle();
    repeat (6) @(posedge i_clock);
  endtask

  task automatic t_reset();
    settle();
    chk("oe_n", poe_n, 8'hff);
    chk("pullup", pup, 8'h00);
    rdc(3'h1, 8'h00);
    rdc(3'h2, 8'hc0);
  endtask
  task automatic t_gpio();
    @(posedge i_clock);
    ext_val <= 8'h3c;
    wr(3'h1, 8'h0f);
    wr(3'h2, 8'ha5);
    wr(3'h5, 8'hff);
    chk("oe_n", poe_n, 8'hf0);
    chk("out", pout & 8'h0f, 8'h05);
    settle();
    rdc(3'h2, 8'hf5);
  endtask
  task automatic t_latch();
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h5a);
    chk("oe_n", poe_n, 8'hff);
    wr(3'h1, 8'hff);
    chk("out", pout, 8'h5a);
    rdc(3'h2, 8'h5a);
  endtask
  task automatic t_pull();
    wr(3'h1, 8'h0f);
    @(posedge i_clock);
    ext_en <= 8'h0f;
    wr(3'h3, 8'hff);
    chk("pullup", pup, 8'h30);
    rdc(3'h3, 8'h3f);
    settle();
    rdc(3'h2, 8'hfa);
    @(posedge i_clock);
    ext_en <= 8'h3f;
    wr(3'h3, 8'h00);
    chk("pullup", pup, 8'h00);
  endtask
  task automatic t_mode();
    wr(3'h1, 8'hff);
    wr(3'h0, 8'h3f);
    chk("oe_n", poe_n, 8'h3f);
    chk("sel", {trig_sel, 1'b0, wk_sel}, 8'hbf);
    rdc(3'h4, 8'hc0);
    @(posedge i_clock);
    ext_val <= 8'h21;
    settle();
    chk("wake", {trig_in, 1'b0, wk_in}, 8'ha1);
    wr(3'h0, 8'h00);
  endtask
  task automatic t_od();
    wr(3'h2, 8'h80);
    wr(3'h0, 8'hc0);
    chk("oe_n", poe_n & 8'hc0, 8'h80);
    wr(3'h0, 8'h00);
    chk("oe_n", poe_n & 8'hc0, 8'h00);
    chk("out", pout & 8'hc0, 8'h80);
  endtask
  task automatic t_tw();
    @(posedge i_clock);
    tw_en <= 1'b1;
    scl_low <= 1'b1;
    @(negedge i_clock);
    chk("tw pads", {4'h0, poe_n[7:6], pout[7:6]}, 8'h04);
    settle();
    chk("tw in", {6'h00, scl_in, sda_in}, 8'h01);
    @(posedge i_clock);
    scl_low <= 1'b0;
    sda_low <= 1'b1;
    @(negedge i_clock);
    chk("tw pads", {4'h0, poe_n[7:6], pout[7:6]}, 8'h08);
    settle();
    chk("tw in", {6'h00, scl_in, sda_in}, 8'h02);
    @(posedge i_clock);
    tw_en <= 1'b0;
    sda_low <= 1'b0;
    @(negedge i_clock);
    chk("oe_n", poe_n & 8'hc0, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_gpio();
    t_latch();
    t_pull();
    t_mode();
    t_od();
    t_tw();
    give_verdict();
  end
endmodule // p5g_port_bench

/* verification/p5g_port_chk.sv */
// p5g_port_chk: relations between the port block's register port and pads
// assumes: bound into p5g_port, sees only its ports
`timescale 1ns/100ps

module p5g_port_chk (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_pin_in,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe_n,
  input wire logic [7:0] o_pin_pullup,
  input wire logic i_twowire_enable,
  input wire logic i_scl_drive_low,
  input wire logic i_sda_drive_low,
  input wire logic o_scl_in,
  input wire logic o_sda_in,
  input wire logic [5:0] o_wakeup_in,
  input wire logic [5:0] o_wakeup_sel,
  input wire logic o_conversion_trigger_in,
  input wire logic o_conversion_trigger_sel
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_pull_rd; i_rd && i_addr == 3'h3 |=> o_rdata[7:6] == 2'b00; endproperty
  a_pull_rd: assert property (p_pull_rd) else $error("reserved pull bits read set");
  property p_pull_in; (o_pin_pullup & ~o_pin_oe_n) == 8'h00; endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull-up on driven pin");
  property p_scl; i_twowire_enable |-> !o_pin_out[7] && o_pin_oe_n[7] == !i_scl_drive_low; endproperty
  a_scl: assert property (p_scl) else $error("clock line not open drain");
  property p_sda; i_twowire_enable |-> !o_pin_out[6] && o_pin_oe_n[6] == !i_sda_drive_low; endproperty
  a_sda: assert property (p_sda) else $error("data line not open drain");
  property p_wake_oe; (o_wakeup_sel & ~o_pin_oe_n[5:0]) == 6'h00; endproperty
  a_wake_oe: assert property (p_wake_oe) else $error("wakeup pin driven");
  property p_trig; o_conversion_trigger_sel == o_wakeup_sel[5] && o_conversion_trigger_in == o_wakeup_in[5];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger differs from pin five");
  // a synchronised rise needs the pad high at the sample taken three edges earlier
  property p_sync; $rose(o_wakeup_in[0]) |-> $past(i_pin_in[0], 3); endproperty
  a_sync: assert property (p_sync) else $error("pin level passed unsynchronised");
  property p_rd_out; i_rd && i_addr == 3'h2 && !o_pin_oe_n[0] |=> o_rdata[0] == $past(o_pin_out[0]); endproperty
  a_rd_out: assert property (p_rd_out) else $error("output bit read not latch");
  c_tw: cover property (i_twowire_enable && i_scl_drive_low);
  c_wake: cover property (o_wakeup_sel == 6'h3f);
  c_rd: cover property (i_rd && i_addr == 3'h2 && !o_pin_oe_n[0]);
endmodule // p5g_port_chk

bind p5g_port p5g_port_chk u_chk (.*);
